// [logic/spx_consts.svh]
// constants of the serial register access slave
`ifndef SPX_CONSTS_SVH
`define SPX_CONSTS_SVH

`define SPX_ADDR_W       14
`define SPX_ORDER_ADDR   14'h3FFF
`define SPX_ORDER_RST    8'h00
`define SPX_ORDER_LSB_A  3
`define SPX_ORDER_LSB_B  4
`define SPX_CTRL_LAST    4'hF
`define SPX_BYTE_LAST    4'h7
`define SPX_ADDR_ONE     14'h0001

`endif

// [logic/spx_pkg.sv]
// types of the serial register access slave
`default_nettype none

package spx_pkg;

    typedef enum logic [1:0] {
        SPX_ST_CTRL,
        SPX_ST_WRITE,
        SPX_ST_READ,
        SPX_ST_DONE
    } spx_state_t;

endpackage : spx_pkg

`default_nettype wire

// [logic/spx_sync.sv]
// two flip-flop synchroniser for one pin
`default_nettype none

module spx_sync (
    input  wire logic clock,
    input  wire logic nrst,
    input  wire logic d,
    output var  logic q
);

    logic meta_r;
    logic meta_nxt;
    logic q_nxt;

    always_comb begin
        meta_nxt = d;
        q_nxt    = meta_r;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            meta_r <= 1'b0;
            q      <= 1'b0;
        end else begin
            meta_r <= meta_nxt;
            q      <= q_nxt;
        end
    end

endmodule : spx_sync

`default_nettype wire

// [logic/spx_slave.sv]
// serial slave port onto the device register space
`include "spx_consts.svh"
`default_nettype none

module spx_slave
    import spx_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        cs_n,
    input  wire logic        sclk,
    input  wire logic        sdi,
    input  wire logic        cpha,
    output var  logic        sdo,
    output var  logic        sdo_oe,
    output var  logic [13:0] reg_addr,
    output var  logic [7:0]  reg_wdata,
    output var  logic        reg_we,
    output var  logic        reg_re,
    input  wire logic [7:0]  reg_rdata,
    output var  logic [7:0]  bit_order
);

    // ==========================================================
    // pin synchronisers
    logic cs_s;
    logic sclk_s;
    logic sdi_s;
    logic cpha_s;

    spx_sync u_sync_cs (
        .clock (clock),
        .nrst  (nrst),
        .d     (cs_n),
        .q     (cs_s)
    );

    spx_sync u_sync_sclk (
        .clock (clock),
        .nrst  (nrst),
        .d     (sclk),
        .q     (sclk_s)
    );

    spx_sync u_sync_sdi (
        .clock (clock),
        .nrst  (nrst),
        .d     (sdi),
        .q     (sdi_s)
    );

    spx_sync u_sync_cpha (
        .clock (clock),
        .nrst  (nrst),
        .d     (cpha),
        .q     (cpha_s)
    );

    // ==========================================================
    // clock edge detection
    logic sclk_q_r;
    logic sclk_q_nxt;
    logic rise;
    logic fall;
    logic samp_edge;
    logic shift_edge;

    always_comb begin
        sclk_q_nxt = sclk_s;
        rise       = sclk_s & ~sclk_q_r;
        fall       = ~sclk_s & sclk_q_r;
        samp_edge  = cpha_s ? fall : rise;
        shift_edge = cpha_s ? rise : fall;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sclk_q_r <= 1'b0;
        end else begin
            sclk_q_r <= sclk_q_nxt;
        end
    end

    // ==========================================================
    // transfer state
    spx_state_t  state_r;
    spx_state_t  state_nxt;
    logic [3:0]  bit_cnt_r;
    logic [3:0]  bit_cnt_nxt;
    logic [2:0]  out_cnt_r;
    logic [2:0]  out_cnt_nxt;
    logic [14:0] sh_r;
    logic [14:0] sh_nxt;
    logic        burst_r;
    logic        burst_nxt;
    logic [13:0] addr_r;
    logic [13:0] addr_nxt;
    logic [7:0]  tx_r;
    logic [7:0]  tx_nxt;
    logic        sdo_r;
    logic        sdo_nxt;
    logic        oe_r;
    logic        oe_nxt;
    logic        we_r;
    logic        we_nxt;
    logic        re_r;
    logic        re_nxt;
    logic [7:0]  wdata_r;
    logic [7:0]  wdata_nxt;
    logic        inc_r;
    logic        inc_nxt;
    logic [7:0]  order_r;
    logic [7:0]  order_nxt;

    logic        lsb;
    logic [15:0] word;
    logic [7:0]  rx_msb;
    logic [7:0]  rx_byte;
    logic [13:0] addr_msb;
    logic [13:0] addr_in;
    logic        tx_bit;

    // ==========================================================
    // word assembly and bit order
    always_comb begin
        lsb      = order_r[`SPX_ORDER_LSB_A] | order_r[`SPX_ORDER_LSB_B];
        word     = {sh_r, sdi_s};
        rx_msb   = {sh_r[6:0], sdi_s};
        addr_msb = word[14:1];
        rx_byte  = rx_msb;
        addr_in  = addr_msb;
        if (lsb) begin
            for (int i = 0; i < 8; i++) begin
                rx_byte[i] = rx_msb[7 - i];
            end
            for (int i = 0; i < `SPX_ADDR_W; i++) begin
                addr_in[i] = addr_msb[13 - i];
            end
        end
        tx_bit = lsb ? tx_r[out_cnt_r] : tx_r[3'h7 - out_cnt_r];
    end

    // ==========================================================
    // next state
    always_comb begin
        state_nxt   = state_r;
        bit_cnt_nxt = bit_cnt_r;
        out_cnt_nxt = out_cnt_r;
        sh_nxt      = sh_r;
        burst_nxt   = burst_r;
        addr_nxt    = addr_r;
        tx_nxt      = tx_r;
        sdo_nxt     = sdo_r;
        oe_nxt      = oe_r;
        we_nxt      = 1'b0;
        re_nxt      = 1'b0;
        wdata_nxt   = wdata_r;
        inc_nxt     = 1'b0;
        order_nxt   = order_r;
        if (inc_r) begin
            addr_nxt = addr_r + `SPX_ADDR_ONE;
        end
        if (re_r) begin
            tx_nxt = (addr_r == `SPX_ORDER_ADDR) ? order_r : reg_rdata;
        end
        if (cs_s) begin
            state_nxt   = SPX_ST_CTRL;
            bit_cnt_nxt = 4'h0;
            out_cnt_nxt = 3'h0;
            burst_nxt   = 1'b0;
            sdo_nxt     = 1'b0;
            oe_nxt      = 1'b0;
        end else begin
            unique case (state_r)
                SPX_ST_CTRL: begin
                    if (samp_edge) begin
                        sh_nxt      = word[14:0];
                        bit_cnt_nxt = bit_cnt_r + 4'h1;
                        if (bit_cnt_r == `SPX_CTRL_LAST) begin
                            bit_cnt_nxt = 4'h0;
                            out_cnt_nxt = 3'h0;
                            burst_nxt   = word[0];
                            addr_nxt    = addr_in;
                            if (word[15]) begin
                                state_nxt = SPX_ST_READ;
                                re_nxt    = 1'b1;
                            end else begin
                                state_nxt = SPX_ST_WRITE;
                            end
                        end
                    end
                end
                SPX_ST_WRITE: begin
                    if (samp_edge) begin
                        sh_nxt      = word[14:0];
                        bit_cnt_nxt = bit_cnt_r + 4'h1;
                        if (bit_cnt_r == `SPX_BYTE_LAST) begin
                            bit_cnt_nxt = 4'h0;
                            wdata_nxt   = rx_byte;
                            inc_nxt     = burst_r;
                            if (addr_r == `SPX_ORDER_ADDR) begin
                                order_nxt = rx_byte;
                            end else begin
                                we_nxt = 1'b1;
                            end
                            if (!burst_r) begin
                                state_nxt = SPX_ST_DONE;
                            end
                        end
                    end
                end
                SPX_ST_READ: begin
                    if (shift_edge) begin
                        sdo_nxt     = tx_bit;
                        oe_nxt      = 1'b1;
                        out_cnt_nxt = out_cnt_r + 3'h1;
                    end
                    if (samp_edge) begin
                        bit_cnt_nxt = bit_cnt_r + 4'h1;
                        if (bit_cnt_r == `SPX_BYTE_LAST) begin
                            bit_cnt_nxt = 4'h0;
                            if (burst_r) begin
                                addr_nxt = addr_r + `SPX_ADDR_ONE;
                                re_nxt   = 1'b1;
                            end else begin
                                state_nxt = SPX_ST_DONE;
                            end
                        end
                    end
                end
                SPX_ST_DONE: begin
                    if (shift_edge) begin
                        oe_nxt = 1'b0;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_r   <= SPX_ST_CTRL;
            bit_cnt_r <= 4'h0;
            out_cnt_r <= 3'h0;
            sh_r      <= 15'h0000;
            burst_r   <= 1'b0;
            addr_r    <= 14'h0000;
            tx_r      <= 8'h00;
            sdo_r     <= 1'b0;
            oe_r      <= 1'b0;
            we_r      <= 1'b0;
            re_r      <= 1'b0;
            wdata_r   <= 8'h00;
            inc_r     <= 1'b0;
            order_r   <= `SPX_ORDER_RST;
        end else begin
            state_r   <= state_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            out_cnt_r <= out_cnt_nxt;
            sh_r      <= sh_nxt;
            burst_r   <= burst_nxt;
            addr_r    <= addr_nxt;
            tx_r      <= tx_nxt;
            sdo_r     <= sdo_nxt;
            oe_r      <= oe_nxt;
            we_r      <= we_nxt;
            re_r      <= re_nxt;
            wdata_r   <= wdata_nxt;
            inc_r     <= inc_nxt;
            order_r   <= order_nxt;
        end
    end

    // ==========================================================
    // outputs
    always_comb begin
        sdo       = sdo_r;
        sdo_oe    = oe_r;
        reg_addr  = addr_r;
        reg_wdata = wdata_r;
        reg_we    = we_r;
        reg_re    = re_r;
        bit_order = order_r;
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    sequence s_enter_read;
        $past(state_r) == SPX_ST_CTRL ##0 state_r == SPX_ST_READ;
    endsequence

    sequence s_select_high;
        cs_s ##1 cs_s;
    endsequence

    property p_oe_read;
        sdo_oe |-> (state_r == SPX_ST_READ || state_r == SPX_ST_DONE);
    endproperty
    a_oe_read: assert property (p_oe_read)
        else $error("data output driven outside a read");

    property p_cs_reset;
        cs_s |=> (state_r == SPX_ST_CTRL && !sdo_oe && bit_cnt_r == 4'h0);
    endproperty
    a_cs_reset: assert property (p_cs_reset)
        else $error("serial logic not reset by select high");

    property p_no_write_deselected;
        s_select_high |-> ##1 !reg_we;
    endproperty
    a_no_write_deselected: assert property (p_no_write_deselected)
        else $error("register write while deselected");

    property p_burst_inc;
        reg_we && burst_r |=> reg_addr == 14'($past(reg_addr) + 14'h1);
    endproperty
    a_burst_inc: assert property (p_burst_inc)
        else $error("burst write address not incremented");

    property p_single_done;
        reg_we && !burst_r |-> state_r == SPX_ST_DONE;
    endproperty
    a_single_done: assert property (p_single_done)
        else $error("single write did not end the access");

    property p_enter_read_fetch;
        s_enter_read |-> reg_re;
    endproperty
    a_enter_read_fetch: assert property (p_enter_read_fetch)
        else $error("read control word without fetch");

    property p_read_inc;
        reg_re && $past(state_r) == SPX_ST_READ
            |-> reg_addr == 14'($past(reg_addr) + 14'h1);
    endproperty
    a_read_inc: assert property (p_read_inc)
        else $error("burst read prefetch address wrong");

    property p_wrap;
        inc_r && reg_addr == 14'h3FFF |=> reg_addr == 14'h0000;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("address counter did not wrap");

    property p_sample_edge;
        !$past(cs_s) && !cs_s && bit_cnt_r != $past(bit_cnt_r) |-> $past(samp_edge);
    endproperty
    a_sample_edge: assert property (p_sample_edge)
        else $error("input sampled off the sampling edge");

    property p_shift_edge;
        !$past(cs_s) && $changed(sdo) |-> $past(shift_edge);
    endproperty
    a_shift_edge: assert property (p_shift_edge)
        else $error("output changed off the shifting edge");

endmodule : spx_slave

`default_nettype wire

// [tb/spx_master.sv]
// behavioural serial bus master for the slave port
`default_nettype none

module spx_master (
    input  wire logic cpha,
    input  wire logic sdo,
    input  wire logic sdo_oe,
    output var  logic cs_n,
    output var  logic sclk,
    output var  logic sdi
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [7:0] wq[$];
    logic [7:0] rq[$];
    int         oe_bad;

    initial begin
        cs_n   = 1'b1;
        sclk   = 1'b0;
        sdi    = 1'b0;
        oe_bad = 0;
    end

    // ==========================================
    // one bit slot: drive, sample, check enable
    task automatic bit_io(input logic d, input logic oe_exp, output logic q);
        if (cpha) begin
            sclk = 1'b1;
        end
        sdi = d;
        #400 sclk = ~sclk;
        q = sdo_oe ? sdo : ~sdo;
        if (sdo_oe !== oe_exp) begin
            oe_bad++;
        end
        #400;
        if (!cpha) begin
            sclk = 1'b0;
        end
    endtask : bit_io

    // ==========================================
    // one frame: control word then data bits
    task automatic frame(input logic rw, input logic [13:0] a, input logic bst,
                         input int nbits, input logic lsb, input int skew);
        logic [15:0] cw;
        logic [7:0]  wb;
        logic [7:0]  rb;
        logic        q;
        int          k;
        cw = {rw, a, bst};
        if (lsb) begin
            for (k = 0; k < 14; k++) cw[14 - k] = a[k];
        end
        rb = 8'h00;
        wb = 8'h00;
        #skew;
        cs_n = 1'b0;
        #400;
        for (k = 0; k < 16; k++) bit_io(cw[15 - k], 1'b0, q);
        for (k = 0; k < nbits; k++) begin
            if (k % 8 == 0) begin
                wb = (wq.size() > 0) ? wq.pop_front() : 8'h3C;
            end
            if (rw) begin
                bit_io(~sdi, 1'b1, q);
                rb[lsb ? k % 8 : 7 - k % 8] = q;
                if (k % 8 == 7) begin
                    rq.push_back(rb);
                end
            end else begin
                bit_io(wb[lsb ? k % 8 : 7 - k % 8], 1'b0, q);
            end
        end
        cs_n = 1'b1;
        sdi  = ~sdi;
    endtask : frame
endmodule : spx_master

`default_nettype wire

// [tb/tb.sv]
// testbench of the serial register access slave
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clock;
    logic        nrst;
    logic        cpha;
    logic        cs_n;
    logic        sclk;
    logic        sdi;
    logic        sdo;
    logic        sdo_oe;
    logic        reg_we;
    logic        reg_re;
    logic [13:0] reg_addr;
    logic [13:0] a;
    logic [7:0]  reg_wdata;
    logic [7:0]  reg_rdata;
    logic [7:0]  bit_order;
    logic [7:0]  dmem [0:16383];
    logic [7:0]  orders [0:3];
    logic [21:0] wlog[$];
    logic [21:0] exp_w[$];
    int          mmem [0:16383];
    int          morder;
    int          seed;
    int          mismatches;
    int          comparisons;
    int          i;
    int          p;

    always #50 clock = ~clock;

    // register space seen by the slave
    assign reg_rdata = reg_re ? dmem[reg_addr] : ~dmem[reg_addr];
    always @(posedge clock) begin
        if (reg_we === 1'b1) begin
            dmem[reg_addr] <= reg_wdata;
            wlog.push_back({reg_addr, reg_wdata});
        end
    end

    spx_slave u_spx_slave (
        .clock(clock), .nrst(nrst), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .cpha(cpha),
        .sdo(sdo), .sdo_oe(sdo_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .bit_order(bit_order)
    );

    spx_master u_spx_master (
        .cpha(cpha), .sdo(sdo), .sdo_oe(sdo_oe), .cs_n(cs_n), .sclk(sclk), .sdi(sdi)
    );

    // ==========================================
    // comparison and closing
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim

    // ==========================================
    // write frame with model update
    task automatic do_write(input logic [13:0] a0, input logic bst, input int nbits,
                            input int fv);
        logic [13:0] ad;
        logic [7:0]  b;
        logic        lsb;
        int          nord;
        int          k;
        ad   = a0;
        nord = morder;
        lsb  = morder[3] | morder[4];
        for (k = 0; k < (nbits + 7) / 8; k++) begin
            b = 8'($random(seed));
            if (ad == 14'h3FFF) begin
                b = (fv >= 0) ? 8'(fv) : 8'(morder);
            end
            u_spx_master.wq.push_back(b);
            if (k < nbits / 8 && (bst || k == 0)) begin
                if (ad == 14'h3FFF) begin
                    nord = b;
                end else begin
                    mmem[ad] = b;
                    exp_w.push_back({ad, b});
                end
            end
            if (bst) begin
                ad = ad + 14'h0001;
            end
        end
        u_spx_master.frame(1'b0, a0, bst, nbits, lsb, 13 + $unsigned($random(seed)) % 60);
        morder = nord;
        repeat (12) @(posedge clock);
        check(wlog.size(), exp_w.size());
        while (wlog.size() > 0 && exp_w.size() > 0) begin
            check(wlog.pop_front(), exp_w.pop_front());
        end
        wlog.delete();
        exp_w.delete();
    endtask : do_write

    // ==========================================
    // read frame against the model
    task automatic do_read(input logic [13:0] a0, input logic bst, input int nbits);
        logic [13:0] ad;
        ad = a0;
        u_spx_master.frame(1'b1, a0, bst, nbits, morder[3] | morder[4],
                           13 + $unsigned($random(seed)) % 60);
        repeat (12) @(posedge clock);
        check(u_spx_master.rq.size(), nbits / 8);
        while (u_spx_master.rq.size() > 0) begin
            check(u_spx_master.rq.pop_front(), (ad == 14'h3FFF) ? morder : mmem[ad]);
            ad = ad + 14'h0001;
        end
    endtask : do_read

    // ==========================================
    // main sequence
    initial begin
        clock       = 1'b0;
        nrst        = 1'b0;
        cpha        = 1'b0;
        seed        = 32'hD635;
        mismatches  = 0;
        comparisons = 0;
        morder      = 0;
        orders      = '{8'h00, 8'h08, 8'h10, 8'hE7};
        for (i = 0; i < 16384; i++) begin
            p       = $random(seed);
            dmem[i] = 8'(p);
            mmem[i] = p & 255;
        end
        repeat (20) @(posedge clock);
        nrst <= 1'b1;
        repeat (5) @(posedge clock);
        check(bit_order, 8'h00);
        check(sdo_oe, 1'b0);
        for (p = 0; p < 4; p++) begin
            @(posedge clock);
            cpha <= p[0];
            a    <= 14'($random(seed)) & 14'h3FF0;
            repeat (5) @(posedge clock);
            do_write(14'h3FFF, 1'b0, 8, int'(orders[p]));
            check(bit_order, orders[p]);
            do_write(a, 1'b0, 8, -1);
            do_read(a, 1'b0, 8);
            do_write(a, 1'b0, 16, -1);
            do_write(14'h3FFE, 1'b1, 32, -1);
            do_read(14'h3FFD, 1'b1, 40);
            do_write(a + 14'h0001, 1'b0, 5, -1);
            do_write(a + 14'h0002, 1'b1, 19, -1);
            do_read(a + 14'h0004, 1'b1, 12);
            do_read(a, 1'b1, 32);
        end
        check(u_spx_master.oe_bad, 0);
        end_sim();
    end

    // hang guard
    initial begin
        repeat (60000) @(posedge clock);
        mismatches++;
        end_sim();
    end
endmodule : tb

`default_nettype wire
